// *** pkg/mad_cfg.svh ***
`ifndef MAD_CFG_SVH
`define MAD_CFG_SVH

// byte lane patterns, lane 3 down to lane 0, active low
`define MAD_LANES_BYTE0   4'he
`define MAD_LANES_BYTE1   4'hd
`define MAD_LANES_BYTE2   4'hb
`define MAD_LANES_BYTE3   4'h7
`define MAD_LANES_INT_LO  4'hc
`define MAD_LANES_INT_HI  4'h3
`define MAD_LANES_FLOAT   4'h0
`define MAD_LANES_NONE    4'hf

// region boundaries (byte addresses)
`define MAD_BANK0_TOP     16'hdfff
`define MAD_BANK1_BASE    16'he000
`define MAD_RESET_ADDR    16'h0000
`define MAD_ROM_LO_TOP    16'h07ff
`define MAD_RAM1_TOP      16'h0fff
`define MAD_ROM_HI_TOP    16'he7ff
`define MAD_RAM_HI_BASE   16'hf000
`define MAD_RAM_HI1_BASE  16'hf800

// on-chip sizes in 32-bit words
`define MAD_ROM_WORDS     512
`define MAD_RAM_WORDS     1024
`define MAD_WADDR_W       14

`endif

// *** pkg/mad_pkg.sv ***
package mad_pkg;

  typedef enum logic [1:0] {
    MAD_DT_BYTE  = 2'h0,
    MAD_DT_HALF  = 2'h1,
    MAD_DT_FLOAT = 2'h2
  } mad_dtype_type;

  typedef enum logic [1:0] {
    MAD_SRC_PC     = 2'h0,
    MAD_SRC_PTR    = 2'h1,
    MAD_SRC_DIRECT = 2'h2
  } mad_source_type;

  typedef enum logic [3:0] {
    MAD_TGT_NONE = 4'h1,
    MAD_TGT_ROM  = 4'h2,
    MAD_TGT_RAM  = 4'h4,
    MAD_TGT_EXT  = 4'h8
  } mad_target_type;

  typedef struct packed {
    logic           valid;
    mad_dtype_type  dtype;
    mad_source_type source;
    logic [15:0]    pc_addr;
    logic [15:0]    ptr_addr;
    logic [15:0]    direct_addr;
  } mad_request_type;

  typedef struct packed {
    logic        valid;
    logic [13:0] word_addr;
    logic [3:0]  byte_lane_select_n;
    logic        rom_en;
    logic        ram_en;
    logic        ext_en;
    logic        bank;
    logic        align_error;
    logic        same_bank;
  } mad_result_type;

endpackage

// *** design/mad_decoder.sv ***
// Summary of operation
// R1 - float addresses multiple of four, word fully split
// R2 - integer addresses multiple of two
// R3 - byte 3 most significant, byte 0 least
// R4 - halfword is bytes 1,0 or 3,2
// R5 - lane select patterns per data type
// R6 - lanes from data type and two address LSBs
// R7 - 14-bit word address selects one word
// R8 - below 0xe000 bank 0, above bank 1
// R9 - first fetch after reset at address zero
// R10 - map modes 0 and 1 region table
// R11 - map modes 2 and 3 region table
// R12 - 64K bytes with external, 6K without; the on-chip map gives 6K bytes (2K ROM, 4K RAM) in every mode
// R13 - without external port, external regions unavailable
// R14 - only bank 0 expands off-chip, half rate
// R15 - alternating banks give full throughput
// R16 - unmapped address: no lanes, no enables
`timescale 1ns/10ps
`include "mad_cfg.svh"

module mad_decoder #(
  parameter bit HAS_EXT_PORT = 1'b1
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // map mode straps
  input  wire logic                     map_mode_pin_low,
  input  wire logic                     map_mode_pin_high,
  // access request
  input  wire mad_pkg::mad_request_type req,
  // decoded access
  output mad_pkg::mad_result_type       res,
  output logic [15:0]                   fetch_addr
);

  // ------------------------------------------------------------
  // strap synchroniser, three stages
  // ------------------------------------------------------------
  logic [1:0] mode_s1_reg;
  logic [1:0] mode_s2_reg;
  logic [1:0] mode_s3_reg;
  logic [1:0] mode_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_s1_reg <= 2'h0;
      mode_s2_reg <= 2'h0;
      mode_s3_reg <= 2'h0;
    end else begin
      mode_s1_reg <= {map_mode_pin_high, map_mode_pin_low};
      mode_s2_reg <= mode_s1_reg;
      mode_s3_reg <= mode_s2_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_reg <= 2'h0;
    end else if (mode_s2_reg == mode_s3_reg) begin
      mode_reg <= mode_s3_reg;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // lane pattern for a data type and the two address LSBs
  function automatic logic [3:0] lanes_of(mad_pkg::mad_dtype_type dt,
                                          logic [1:0] lsb);
    logic [3:0] l;
    l = `MAD_LANES_NONE;
    unique case (dt)
      mad_pkg::MAD_DT_BYTE: begin
        unique case (lsb)                               // [R3] [R6]
          2'h0: l = `MAD_LANES_BYTE0;                   // [R5]
          2'h1: l = `MAD_LANES_BYTE1;
          2'h2: l = `MAD_LANES_BYTE2;
          2'h3: l = `MAD_LANES_BYTE3;
        endcase
      end
      mad_pkg::MAD_DT_HALF: begin
        if (lsb == 2'h0) begin                          // [R4]
          l = `MAD_LANES_INT_LO;
        end else if (lsb == 2'h2) begin
          l = `MAD_LANES_INT_HI;
        end
      end
      mad_pkg::MAD_DT_FLOAT: begin
        if (lsb == 2'h0) begin                          // [R1]
          l = `MAD_LANES_FLOAT;
        end
      end
      default: l = `MAD_LANES_NONE;
    endcase
    return l;
  endfunction

  // misaligned access check
  function automatic logic misaligned(mad_pkg::mad_dtype_type dt,
                                      logic [1:0] lsb);
    logic m;
    m = 1'b0;
    if (dt == mad_pkg::MAD_DT_HALF) begin
      m = lsb[0];                                       // [R2]
    end else if (dt == mad_pkg::MAD_DT_FLOAT) begin
      m = (lsb != 2'h0);                                // [R1]
    end
    return m;
  endfunction

  // bank of a byte address: the top 8K bytes form bank 1
  function automatic logic bank_of(logic [15:0] a);
    return (a >= `MAD_BANK1_BASE);                      // [R8]
  endfunction

  // region lookup for the selected map mode
  function automatic mad_pkg::mad_target_type region(logic [1:0] mode,
                                                     logic [15:0] a);
    mad_pkg::mad_target_type t;
    t = mad_pkg::MAD_TGT_NONE;
    unique case (mode)
      2'h0: begin                                       // [R10]
        if (a <= `MAD_ROM_LO_TOP) t = mad_pkg::MAD_TGT_ROM;
        else if (a <= `MAD_BANK0_TOP) t = mad_pkg::MAD_TGT_EXT;
        else if (a >= `MAD_RAM_HI_BASE) t = mad_pkg::MAD_TGT_RAM;
      end
      2'h1: begin                                       // [R10]
        if (a <= `MAD_ROM_LO_TOP) t = mad_pkg::MAD_TGT_ROM;
        else if (a <= `MAD_RAM1_TOP) t = mad_pkg::MAD_TGT_RAM;
        else if (a <= `MAD_BANK0_TOP) t = mad_pkg::MAD_TGT_EXT;
        else if (a >= `MAD_RAM_HI1_BASE) t = mad_pkg::MAD_TGT_RAM;
      end
      2'h2: begin                                       // [R11]
        if (a <= `MAD_BANK0_TOP) t = mad_pkg::MAD_TGT_EXT;
        else if (a <= `MAD_ROM_HI_TOP) t = mad_pkg::MAD_TGT_ROM;
        else if (a >= `MAD_RAM_HI_BASE) t = mad_pkg::MAD_TGT_RAM;
      end
      2'h3: begin                                       // [R11]
        if (a <= `MAD_ROM_LO_TOP) t = mad_pkg::MAD_TGT_RAM;
        else if (a <= `MAD_BANK0_TOP) t = mad_pkg::MAD_TGT_EXT;
        else if (a <= `MAD_ROM_HI_TOP) t = mad_pkg::MAD_TGT_ROM;
        else if (a >= `MAD_RAM_HI1_BASE) t = mad_pkg::MAD_TGT_RAM;
      end
    endcase
    // external regions exist only with the port; bank 1 never off-chip
    if (t == mad_pkg::MAD_TGT_EXT &&
        (!HAS_EXT_PORT || a > `MAD_BANK0_TOP)) begin    // [R13] [R14]
      t = mad_pkg::MAD_TGT_NONE;
    end
    return t;
  endfunction

  // ------------------------------------------------------------
  // address source selection
  // ------------------------------------------------------------
  logic [15:0]             addr;
  mad_pkg::mad_target_type tgt;
  logic                    bad;
  logic [3:0]              lanes;

  always_comb begin
    unique case (req.source)
      mad_pkg::MAD_SRC_PC:     addr = req.pc_addr;
      mad_pkg::MAD_SRC_PTR:    addr = req.ptr_addr;
      mad_pkg::MAD_SRC_DIRECT: addr = req.direct_addr;
      default:                 addr = req.direct_addr;
    endcase
  end

  always_comb begin
    tgt   = region(mode_reg, addr);                     // [R12]
    bad   = misaligned(req.dtype, addr[1:0]);
    lanes = lanes_of(req.dtype, addr[1:0]);             // [R6]
    if (tgt == mad_pkg::MAD_TGT_NONE || bad) begin
      lanes = `MAD_LANES_NONE;                          // [R16]
    end
  end

  // ------------------------------------------------------------
  // registered result
  // ------------------------------------------------------------
  localparam int WADDR_W = `MAD_WADDR_W;

  logic               ok;
  logic               acc_bank;
  logic               valid_reg;
  logic [WADDR_W-1:0] word_addr_reg;
  logic               bank_reg;
  logic [3:0]         lanes_reg;
  logic               rom_en_reg;
  logic               ram_en_reg;
  logic               ext_en_reg;
  logic               align_error_reg;
  logic               last_bank_reg;
  logic               have_last_reg;
  logic               same_bank_reg;
  logic [15:0]        fetch_addr_reg;

  // an access is served only when requested and aligned
  always_comb begin
    ok       = req.valid && !bad;
    acc_bank = bank_of(addr);
  end

  // ------------------------------------------------------------
  // address path
  // ------------------------------------------------------------
  // word address and bank follow addr even when nothing is requested
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      valid_reg     <= 1'b0;
      word_addr_reg <= '0;
      bank_reg      <= 1'b0;
    end else begin
      valid_reg     <= req.valid;
      word_addr_reg <= addr[15:2];                      // [R7]
      bank_reg      <= acc_bank;                        // [R8]
    end
  end

  // ------------------------------------------------------------
  // lane selects
  // ------------------------------------------------------------
  // lanes idle high while no access is requested
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lanes_reg <= `MAD_LANES_NONE;
    end else if (req.valid) begin
      lanes_reg <= lanes;                               // [R5] [R16]
    end else begin
      lanes_reg <= `MAD_LANES_NONE;
    end
  end

  // ------------------------------------------------------------
  // memory enables
  // ------------------------------------------------------------
  // at most one enable per access, none for a refused one
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rom_en_reg <= 1'b0;
      ram_en_reg <= 1'b0;
      ext_en_reg <= 1'b0;
    end else begin
      rom_en_reg <= ok && tgt == mad_pkg::MAD_TGT_ROM;  // [R16]
      ram_en_reg <= ok && tgt == mad_pkg::MAD_TGT_RAM;
      ext_en_reg <= ok && tgt == mad_pkg::MAD_TGT_EXT;  // [R14]
    end
  end

  // ------------------------------------------------------------
  // alignment flag
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      align_error_reg <= 1'b0;
    end else begin
      align_error_reg <= req.valid && bad;              // [R1] [R2]
    end
  end

  // ------------------------------------------------------------
  // bank history
  // ------------------------------------------------------------
  // remembers the bank of the last requested access
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      last_bank_reg <= 1'b0;
      have_last_reg <= 1'b0;
    end else if (req.valid) begin
      last_bank_reg <= acc_bank;                        // [R15]
      have_last_reg <= 1'b1;
    end
  end

  // flags a request to the same bank as the last requested access, even after idle cycles, which halves throughput
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      same_bank_reg <= 1'b0;
    end else begin
      same_bank_reg <= req.valid && have_last_reg &&
                       last_bank_reg == acc_bank;       // [R15]
    end
  end

  // ------------------------------------------------------------
  // result bundle
  // ------------------------------------------------------------
  // every field comes straight from its register
  assign res = '{
    valid:              valid_reg,
    word_addr:          word_addr_reg,
    byte_lane_select_n: lanes_reg,
    rom_en:             rom_en_reg,
    ram_en:             ram_en_reg,
    ext_en:             ext_en_reg,
    bank:               bank_reg,
    align_error:        align_error_reg,
    same_bank:          same_bank_reg
  };

  // ------------------------------------------------------------
  // reset fetch address
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fetch_addr_reg <= `MAD_RESET_ADDR;                // [R9]
    end else if (req.valid && req.source == mad_pkg::MAD_SRC_PC) begin
      fetch_addr_reg <= req.pc_addr;
    end
  end

  assign fetch_addr = fetch_addr_reg;

endmodule

// *** verification/mad_chk_sva.sv ***
`timescale 1ns/10ps
module mad_chk (
  // clock and reset
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  // straps, request and result
  input wire logic                     map_mode_pin_low,
  input wire logic                     map_mode_pin_high,
  input wire mad_pkg::mad_request_type req,
  input wire mad_pkg::mad_result_type  res,
  input wire logic [15:0]              fetch_addr
);
  logic [15:0] a;
  logic [3:0]  ln;
  logic        mis;
  logic        en;
  assign a = (req.source == mad_pkg::MAD_SRC_PC) ? req.pc_addr :
             (req.source == mad_pkg::MAD_SRC_PTR) ? req.ptr_addr :
             req.direct_addr;
  assign mis = (req.dtype == mad_pkg::MAD_DT_FLOAT) ? |a[1:0] :
               (req.dtype == mad_pkg::MAD_DT_HALF) & a[0];
  assign ln = (req.dtype == mad_pkg::MAD_DT_FLOAT) ? 4'h0 :
              (req.dtype == mad_pkg::MAD_DT_HALF) ? (a[1] ? 4'h3 : 4'hc) :
              ~(4'h1 << a[1:0]);
  assign en = res.rom_en | res.ram_en | res.ext_en;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_word;
    $past(rst_n) |-> res.word_addr == $past(a[15:2]);
  endproperty
  a_word: assert property (p_word) else $error("word address wrong");
  property p_bank;
    $past(rst_n) |-> res.bank == ($past(a) >= 16'he000);
  endproperty
  a_bank: assert property (p_bank) else $error("bank wrong");
  property p_lanes;
    en |-> res.byte_lane_select_n == $past(ln);
  endproperty
  a_lanes: assert property (p_lanes) else $error("lanes wrong");
  property p_misal;
    $past(rst_n && req.valid && mis) |->
      res.align_error && res.byte_lane_select_n == 4'hf && !en;
  endproperty
  a_misal: assert property (p_misal) else $error("misalign");
  property p_unmap;
    $past(rst_n && a[15:11] == 5'h1d) |->
      res.byte_lane_select_n == 4'hf && !en;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped hit");
  property p_ramtop;
    $past(rst_n && req.valid && !mis && a[15:11] == 5'h1f) |->
      res.ram_en && !res.rom_en && !res.ext_en;
  endproperty
  a_ramtop: assert property (p_ramtop) else $error("top ram");
  property p_extb0;
    res.ext_en |-> !res.bank;
  endproperty
  a_extb0: assert property (p_extb0) else $error("ext in bank 1");
  property p_one;
    $onehot0({res.rom_en, res.ram_en, res.ext_en});
  endproperty
  a_one: assert property (p_one) else $error("two targets");
  property p_fetch;
    $past(!rst_n) |-> fetch_addr == 16'h0000;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not zero");
endmodule

bind mad_decoder mad_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .map_mode_pin_low(map_mode_pin_low), .map_mode_pin_high(map_mode_pin_high),
  .req(req), .res(res), .fetch_addr(fetch_addr));

// *** verification/mad_ext_mem.sv ***
`timescale 1ns/10ps
module mad_ext_mem (
  // clock, reset and decoded access
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  input wire mad_pkg::mad_result_type res,
  output logic [31:0]                 ext_hits
);
  // counts word cycles that reach external memory
  always_ff @(posedge clk_sys) begin
    if (!rst_n) ext_hits <= 32'h0;
    else if (res.ext_en && !res.bank) ext_hits <= ext_hits + 32'h1;
  end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/10ps
module tb;
  logic                    clk_sys;
  logic                    rst_n;
  logic [1:0]              mm;
  mad_pkg::mad_request_type req;
  mad_pkg::mad_result_type  res;
  mad_pkg::mad_result_type  res_nx;
  logic [15:0]             fetch_addr;
  logic [31:0]             ext_hits;
  logic [31:0]             exp_ext;
  int                      fail_count = 0;
  int                      samples_checked = 0;
  mad_decoder dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .map_mode_pin_low(mm[0]), .map_mode_pin_high(mm[1]),
    .req(req), .res(res), .fetch_addr(fetch_addr));
  mad_decoder #(.HAS_EXT_PORT(1'b0)) dut_noext (.clk_sys(clk_sys),
    .rst_n(rst_n), .map_mode_pin_low(mm[0]), .map_mode_pin_high(mm[1]),
    .req(req), .res(res_nx), .fetch_addr());
  mad_ext_mem mem (.clk_sys(clk_sys), .rst_n(rst_n), .res(res),
    .ext_hits(ext_hits));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic acc(input int d, input int s, input logic [15:0] ad);
    @(posedge clk_sys);
    req.valid <= 1'b1;
    req.dtype <= mad_pkg::mad_dtype_type'(d);
    req.source <= mad_pkg::mad_source_type'(s);
    req.pc_addr <= (s == 0) ? ad : ~ad;
    req.ptr_addr <= (s == 1) ? ad : ~ad;
    req.direct_addr <= (s == 2) ? ad : ~ad;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(20'h0000f, {fetch_addr, res.byte_lane_select_n});
    @(posedge clk_sys);
    rst_n <= 1'b1;
    $display("reset done");
  endtask
  task automatic t_lanes;
    logic [3:0] lt [7] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'h0};
    logic [1:0] off [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0};
    for (int i = 0; i < 7; i++) begin
      acc((i < 4) ? 0 : (i < 6) ? 1 : 2, i % 3, {14'h3e40, off[i]});
      chk({14'h3e40, lt[i], 2'h3}, {res.word_addr,
        res.byte_lane_select_n, res.ram_en,
        res.valid});
    end
    chk(16'hf900, fetch_addr);
    $display("t_lanes done");
  endtask
  task automatic t_map;
    logic [31:0] tbl [4] = '{32'h41110022, 32'h42110002,
                             32'h11114022, 32'h21114002};
    logic [15:0] ad [8] = '{16'h0000, 16'h0800, 16'h1000, 16'hdffc,
                            16'he000, 16'he800, 16'hf000, 16'hf800};
    logic [2:0]  t;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      mm <= 2'(m);
      repeat (8) @(posedge clk_sys);
      for (int j = 0; j < 8; j++) begin
        t = tbl[m][4 * (7 - j) +: 3];
        // a request stays on the inputs across two sampling edges
        if (t == 3'h1) exp_ext += 32'h2;
        acc(2, 2, ad[j]);
        chk({t, ad[j] >= 16'he000}, {res.rom_en, res.ram_en,
          res.ext_en, res.bank});
        chk((t != 3'h0) ? 4'h0 : 4'hf, res.byte_lane_select_n);
        chk({t & 3'h6, ((t & 3'h6) != 3'h0) ? 4'h0 : 4'hf},
          {res_nx.rom_en, res_nx.ram_en, res_nx.ext_en,
          res_nx.byte_lane_select_n});
      end
    end
    chk(exp_ext, ext_hits);
    $display("t_map done");
  endtask
  task automatic t_align;
    acc(1, 1, 16'hf801);
    chk(6'h3e, {res.align_error, res.byte_lane_select_n,
      res.rom_en | res.ram_en | res.ext_en});
    acc(2, 0, 16'hf802);
    chk(6'h3e, {res.align_error, res.byte_lane_select_n,
      res.rom_en | res.ram_en | res.ext_en});
    $display("t_align done");
  endtask
  task automatic t_bank;
    logic [15:0] ad [4] = '{16'h0000, 16'he000, 16'he004, 16'h0010};
    logic [1:0]  sb [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
    for (int i = 0; i < 4; i++) begin
      acc(2, 2, ad[i]);
      chk({1'b1, sb[i]}, {res.valid, res.bank, res.same_bank});
    end
    @(posedge clk_sys);
    req.valid <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(7'h3c, {res.valid, res.byte_lane_select_n,
      res.rom_en | res.ram_en | res.ext_en, res.same_bank});
    acc(0, 2, 16'h0020);
    chk(2'h1, {res.bank, res.same_bank});
    $display("t_bank done");
  endtask
  initial begin
    #100000;
    fail_count++;
    print_verdict;
  end
  initial begin
    rst_n = 1'b0;
    mm = 2'h0;
    req = '0;
    exp_ext = 32'h0;
    do_reset;
    t_lanes;
    t_map;
    t_align;
    t_bank;
    do_reset;
    print_verdict;
  end
endmodule
